// *** src/gain_pkg.sv ***
// Constants, types and state layout for the gain and power estimator.
// Assumes one conversion clock of 40 MHz and a synchronous reset.
//
// Overview of operation
// - Fine gain 0 to 6 dB, half-dB steps
// - Codes 0..12 give code times 0.5 dB
// - Gain code is zero after reset
// - Level bus driven only while meter enabled
// - Power averaged over programmable sample count
// - Level codes 1..14, one-dB bins from -12.5 to -1.5 dBFS
// - Length code 0..4 selects 1K..16K samples
// - Samples leave pipeline 21 cycles after sampling
// - Output 12 bits, offset binary or two's complement
package gain_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int CODE_W = 12;
    localparam int GAIN_W = 4;
    localparam int LEN_W = 3;
    localparam int LEVEL_W = 4;
    localparam int PIPE_LAT = 21;
    localparam int DLY_STAGES = PIPE_LAT - 1;
    localparam int FIFO_DEPTH = 16;
    localparam int GAIN_FRAC = 10;
    localparam int PROD_W = 25;
    localparam int SQ_W = 23;
    localparam int ACC_W = 37;
    localparam int CNT_W = 14;
    localparam int RUN_W = 5;
    localparam int N_THRESH = 13;

    localparam logic [GAIN_W-1:0] GAIN_RESET = 4'h0;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hc;
    localparam logic [LEN_W-1:0] LEN_RESET = 3'h0;
    localparam logic [LEN_W-1:0] LEN_MAX = 3'h4;
    localparam logic [3:0] WIN_BASE_LOG2 = 4'ha;
    localparam logic [LEVEL_W-1:0] LEVEL_OFF = 4'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_MIN = 4'h1;
    localparam logic [LEVEL_W-1:0] LEVEL_TOP = 4'he;

    // Q10 factors: ratio of 2.00 Vpp to each scaled full scale
    localparam logic [11:0] GAIN_Q10 [0:12] = '{
        12'h400, 12'h43c, 12'h47f, 12'h4c3, 12'h508, 12'h555, 12'h5a2,
        12'h5f8, 12'h659, 12'h6b9, 12'h725, 12'h78c, 12'h800
    };

    // Mean square at -12.5 .. -1.5 and 0 dBFS, full-scale sine reference
    localparam logic [SQ_W-1:0] PWR_THRESH [0:N_THRESH-1] = '{
        23'h01ccaa, 23'h0243f3, 23'h02da1c, 23'h039727, 23'h048524,
        23'h05b0c3, 23'h0729f5, 23'h0904ce, 23'h0b5a9d, 23'h0e4b2d,
        23'h11fea2, 23'h16a778, 23'h200000
    };

    typedef struct packed {
        logic gain_wr;
        logic [GAIN_W-1:0] gain_code;
        logic level_meter_on;
        logic [LEN_W-1:0] averaging_length_code;
        logic twos_comp;
    } ctrl_t;

    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic [DLY_STAGES-1:0][CODE_W-1:0] dly;
        logic [DLY_STAGES-1:0] dv;
        logic signed [PROD_W-1:0] prod;
        logic pv;
        logic [CODE_W-1:0] out;
        logic ov;
        logic [LEN_W-1:0] len;
        logic [CNT_W-1:0] cnt;
        logic [ACC_W-1:0] acc;
        logic [LEVEL_W-1:0] level;
        logic [LEVEL_W-1:0] level_out;
    } core_t;

endpackage

// *** src/sample_fifo.sv ***
// Sample FIFO with registered read data and valid/ready on both sides.
// Assumes producer and consumer share one clock and a synchronous reset.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] dout;
        logic dv;
    } fifo_t;

    fifo_t st_ff;
    fifo_t nxt_st;
    logic push;
    logic take;

    assign in_ready_o = st_ff.cnt < (AW+1)'(DEPTH);
    assign out_valid_o = st_ff.dv;
    assign out_data_o = st_ff.dout;

    always_comb begin
        nxt_st = st_ff;
        push = in_valid_i && in_ready_o;
        take = 1'b0;
        // Head register refills as soon as it is free or drained
        if (!st_ff.dv || out_ready_i) begin
            if (st_ff.cnt != '0) begin
                take = 1'b1;
                nxt_st.dout = st_ff.mem[st_ff.rp];
                nxt_st.dv = 1'b1;
                nxt_st.rp = st_ff.rp + 1'b1;
            end else begin
                nxt_st.dv = 1'b0;
            end
        end
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_data_i;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        unique case ({push, take})
            2'b10: nxt_st.cnt = st_ff.cnt + 1'b1;
            2'b01: nxt_st.cnt = st_ff.cnt - 1'b1;
            default: nxt_st.cnt = st_ff.cnt;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    property p_fifo_no_overrun;
        @(posedge clk_i) disable iff (srst_i)
        st_ff.cnt == (AW+1)'(DEPTH) |-> !in_ready_o;
    endproperty
    a_fifo_no_overrun: assert property (p_fifo_no_overrun)
        else $error("fifo accepts data while full");

endmodule

// *** src/gain_and_power_estimator.sv ***
// Post-conversion fine gain, output coding and coarse power meter.
// Assumes raw offset-binary codes on the conversion clock and a
// control port on the same clock; output drained through a FIFO.
`timescale 1ns/1ps
module gain_and_power_estimator (
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic [gain_pkg::CODE_W-1:0] SAMPLE_I,
    input wire logic SAMPLE_VALID_I,
    output logic SAMPLE_READY_O,
    input wire gain_pkg::ctrl_t CTRL_I,
    output logic [gain_pkg::CODE_W-1:0] DATA_O,
    output logic DATA_VALID_O,
    input wire logic DATA_READY_I,
    output logic [gain_pkg::LEVEL_W-1:0] LEVEL_O
);
    gain_pkg::core_t st_ff;
    gain_pkg::core_t nxt_st;
    logic fifo_rdy;
    logic advance;
    logic win_end;
    logic signed [gain_pkg::CODE_W-1:0] top_s;
    logic signed [gain_pkg::PROD_W-gain_pkg::GAIN_FRAC-1:0] shf;
    logic signed [gain_pkg::CODE_W-1:0] sat;
    logic signed [2*gain_pkg::CODE_W-1:0] sq_full;
    logic [gain_pkg::SQ_W-1:0] sq;
    logic [gain_pkg::ACC_W-1:0] sum;
    logic [gain_pkg::SQ_W-1:0] avg;
    logic [3:0] shamt;
    logic [gain_pkg::CNT_W:0] win_len;
    logic [gain_pkg::LEVEL_W-1:0] lvl;

    ////////////////////////////////////////////////////////////////////
    // Output buffer

    sample_fifo #(
        .WIDTH(gain_pkg::CODE_W),
        .DEPTH(gain_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(REF_CLK_I),
        .srst_i(SRST_I),
        .in_valid_i(st_ff.ov),
        .in_ready_o(fifo_rdy),
        .in_data_i(st_ff.out),
        .out_valid_o(DATA_VALID_O),
        .out_ready_i(DATA_READY_I),
        .out_data_o(DATA_O)
    );

    // Whole pipeline freezes while a finished sample waits on the FIFO
    assign advance = !st_ff.ov || fifo_rdy;
    assign SAMPLE_READY_O = advance;
    assign LEVEL_O = st_ff.level_out;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        nxt_st = st_ff;
        top_s = $signed({~st_ff.dly[gain_pkg::DLY_STAGES-1][11],
                         st_ff.dly[gain_pkg::DLY_STAGES-1][10:0]});
        shf = st_ff.prod[gain_pkg::PROD_W-1:gain_pkg::GAIN_FRAC];
        // Gain above 0 dB can overrange; clip rather than wrap
        if (shf > 15'sh07ff) begin
            sat = 12'sh7ff;
        end else if (shf < -15'sh0800) begin
            sat = -12'sh800;
        end else begin
            sat = shf[gain_pkg::CODE_W-1:0];
        end
        sq_full = sat * sat;
        sq = sq_full[gain_pkg::SQ_W-1:0];
        sum = st_ff.acc + gain_pkg::ACC_W'(sq);
        shamt = gain_pkg::WIN_BASE_LOG2 + 4'(st_ff.len);
        win_len = (gain_pkg::CNT_W+1)'(1) << shamt;
        win_end = advance && st_ff.pv
            && ({1'b0, st_ff.cnt} == win_len - 1'b1);
        avg = gain_pkg::SQ_W'(sum >> shamt);
        lvl = gain_pkg::LEVEL_MIN;
        for (int i = 0; i < gain_pkg::N_THRESH; i++) begin
            if (avg >= gain_pkg::PWR_THRESH[i]) begin
                lvl = lvl + 1'b1;
            end
        end

        nxt_st.level_out = CTRL_I.level_meter_on ? st_ff.level
                                                 : gain_pkg::LEVEL_OFF;
        // Reserved codes are dropped so the gain stays defined
        if (CTRL_I.gain_wr && CTRL_I.gain_code <= gain_pkg::GAIN_MAX) begin
            nxt_st.gain = CTRL_I.gain_code;
        end

        if (advance) begin
            nxt_st.dly = {st_ff.dly[gain_pkg::DLY_STAGES-2:0], SAMPLE_I};
            nxt_st.dv = {st_ff.dv[gain_pkg::DLY_STAGES-2:0],
                         SAMPLE_VALID_I};
            nxt_st.prod = top_s * $signed({1'b0,
                gain_pkg::GAIN_Q10[st_ff.gain]});
            nxt_st.pv = st_ff.dv[gain_pkg::DLY_STAGES-1];
            nxt_st.ov = st_ff.pv;
            nxt_st.out = CTRL_I.twos_comp ? sat
                                          : {~sat[11], sat[10:0]};
            if (win_end) begin
                nxt_st.level = lvl;
                nxt_st.acc = '0;
                nxt_st.cnt = '0;
                nxt_st.len = (CTRL_I.averaging_length_code > gain_pkg::LEN_MAX)
                    ? gain_pkg::LEN_MAX : CTRL_I.averaging_length_code;
            end else if (st_ff.pv) begin
                nxt_st.acc = sum;
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic [gain_pkg::RUN_W-1:0] run_ff;
    logic [gain_pkg::CNT_W:0] seen_ff;

    // Consecutive advancing edges, saturating
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I || !advance) begin
            run_ff <= '0;
        end else if (run_ff != '1) begin
            run_ff <= run_ff + 1'b1;
        end
    end

    // Samples counted into the running window
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I || win_end) begin
            seen_ff <= '0;
        end else if (advance && st_ff.pv) begin
            seen_ff <= seen_ff + 1'b1;
        end
    end

    sequence s_accept;
        SAMPLE_VALID_I && SAMPLE_READY_O;
    endsequence

    sequence s_window_end;
        win_end ##1 1'b1;
    endsequence

    property p_gain_reset;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        $fell(SRST_I) |-> st_ff.gain == gain_pkg::GAIN_RESET;
    endproperty
    a_gain_reset: assert property (p_gain_reset)
        else $error("gain not zero after reset");

    property p_gain_range;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        st_ff.gain <= gain_pkg::GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range)
        else $error("gain code beyond 6 dB");

    property p_gain_load;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        CTRL_I.gain_wr && CTRL_I.gain_code <= gain_pkg::GAIN_MAX
        |=> st_ff.gain == $past(CTRL_I.gain_code) ##1
            (st_ff.gain == $past(CTRL_I.gain_code, 2) || $past(CTRL_I.gain_wr));
    endproperty
    a_gain_load: assert property (p_gain_load)
        else $error("legal gain code not applied");

    property p_unity_gain;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        advance && st_ff.gain == gain_pkg::GAIN_RESET
        |=> st_ff.prod == ($past(top_s) <<< gain_pkg::GAIN_FRAC);
    endproperty
    a_unity_gain: assert property (p_unity_gain)
        else $error("0 dB gain alters the sample");

    property p_accept_flow;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        s_accept |=> st_ff.dv[0];
    endproperty
    a_accept_flow: assert property (p_accept_flow)
        else $error("accepted sample missing from delay line");

    property p_pipe_delay;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        run_ff >= 5'd22 && $past(SAMPLE_VALID_I, 22)
        |-> st_ff.ov;
    endproperty
    a_pipe_delay: assert property (p_pipe_delay)
        else $error("sample not out 21 cycles after sampling");

    property p_format;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        advance && st_ff.pv
        |=> st_ff.out[11] == ($past(sat[11]) ^ !$past(CTRL_I.twos_comp));
    endproperty
    a_format: assert property (p_format)
        else $error("output coding does not follow format");

    property p_level_gate;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        !CTRL_I.level_meter_on |=> LEVEL_O == gain_pkg::LEVEL_OFF;
    endproperty
    a_level_gate: assert property (p_level_gate)
        else $error("level bus driven while meter off");

    property p_level_code;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        s_window_end |-> st_ff.level >= gain_pkg::LEVEL_MIN
            && st_ff.level <= gain_pkg::LEVEL_TOP;
    endproperty
    a_level_code: assert property (p_level_code)
        else $error("level code outside 1 to 14");

    property p_window_len;
        @(posedge REF_CLK_I) disable iff (SRST_I)
        win_end |-> seen_ff + 1'b1 == win_len
            && st_ff.len <= gain_pkg::LEN_MAX;
    endproperty
    a_window_len: assert property (p_window_len)
        else $error("averaging window length wrong");

endmodule

// *** tb/level_reader.sv ***
// Far-side model: board logic that drains the sample stream and reads
// the level bus. Assumes the stream clock and its synchronous reset.
`timescale 1ns/1ps
module level_reader (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic hold_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire logic [11:0] data_i,
    input wire logic [3:0] level_i,
    output logic ready_o,
    output logic take_o,
    output logic [11:0] word_o,
    output logic [3:0] level_o
);
    logic [1:0] tick_ff;
    // Slow mode takes one word in four, so the FIFO backs up
    assign ready_o = !hold_i && (!slow_i || tick_ff == 2'h3);
    assign take_o = valid_i && ready_o;
    assign word_o = data_i;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_ff <= 2'h0;
            level_o <= 4'h0;
        end else begin
            tick_ff <= tick_ff + 2'h1;
            level_o <= level_i;
        end
    end
endmodule

// *** tb/gain_and_power_estimator_test.sv ***
// Bench for the gain and power estimator: gain, latency, FIFO, meter.
// Assumes gain_pkg and the sink model level_reader are compiled first.
`timescale 1ns/1ps
module gain_and_power_estimator_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] smp = 12'h800;
    logic vld = 1'b0;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic saw_low = 1'b0;
    gain_pkg::ctrl_t ctrl = '0;
    logic rdy, dvld, dack, take;
    logic [11:0] dout, word;
    logic [3:0] lvl, lvl_seen;
    logic [11:0] exp_q[$];
    int n_errors = 0;
    int cmp_count = 0;

    gain_and_power_estimator gain_and_power_estimator_i (
        .REF_CLK_I(clk), .SRST_I(srst), .SAMPLE_I(smp),
        .SAMPLE_VALID_I(vld), .SAMPLE_READY_O(rdy), .CTRL_I(ctrl),
        .DATA_O(dout), .DATA_VALID_O(dvld), .DATA_READY_I(dack),
        .LEVEL_O(lvl));
    level_reader level_reader_i (.clk_i(clk), .srst_i(srst), .hold_i(hold),
        .slow_i(slow), .valid_i(dvld), .data_i(dout), .level_i(lvl),
        .ready_o(dack), .take_o(take), .word_o(word), .level_o(lvl_seen));

    initial begin
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic fail(input string m);
        n_errors++;
        $display("Error %0t %s", $time, m);
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [11:0] g, input logic [11:0] e);
        cmp_count++;
        if (g !== e) fail("data word");
    endtask
    task automatic chk_lvl(input logic [3:0] g, input logic [3:0] e);
        cmp_count++;
        if (g !== e) fail("level code");
    endtask
    task automatic chk_flag(input logic g, input logic e);
        cmp_count++;
        if (g !== e) fail("flag");
    endtask
    task automatic chk_cnt(input int g, input int e);
        cmp_count++;
        if (g != e) fail("cycle count");
    endtask

    // Every word the sink takes must be the next one expected, in order
    always @(posedge clk) begin
        if (take === 1'b1) begin
            if (exp_q.size() == 0) fail("extra word");
            else chk_word(word, exp_q.pop_front());
        end
    end

    task automatic send(input logic [11:0] s, input logic [11:0] e);
        int n = 0;
        @(negedge clk);
        vld = 1'b1;
        smp = s;
        while (rdy !== 1'b1) begin
            saw_low = 1'b1;
            @(negedge clk);
            n++;
            if (n > 400) fail("timeout");
            if (n > 400) give_verdict();
        end
        exp_q.push_back(e);
        @(posedge clk);
    endtask
    task automatic drain;
        int n = 0;
        @(negedge clk);
        vld = 1'b0;
        while (exp_q.size() != 0) begin
            @(negedge clk);
            n++;
            if (n > 2000) fail("timeout");
            if (n > 2000) give_verdict();
        end
        repeat (4) @(negedge clk);
    endtask
    task automatic burst(input logic [11:0] s, input logic [11:0] e,
                         input int k);
        repeat (k) send(s, e);
        drain();
    endtask
    task automatic set_gain(input logic [3:0] c);
        @(negedge clk);
        ctrl.gain_wr = 1'b1;
        ctrl.gain_code = c;
        @(negedge clk);
        ctrl.gain_wr = 1'b0;
    endtask
    task automatic do_reset;
        @(negedge clk);
        srst = 1'b1;
        vld = 1'b0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        exp_q.delete();
        chk_flag(dvld, 1'b0);
        chk_lvl(lvl, 4'h0);
        chk_flag(rdy, 1'b1);
    endtask

    // No gain write yet, so 512 must come out unscaled
    task automatic t_latency;
        int n = 0;
        send(12'ha00, 12'h200);
        @(negedge clk);
        vld = 1'b0;
        while (dvld !== 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        // Output register, then FIFO write, then FIFO head register
        chk_cnt(n, gain_pkg::PIPE_LAT + 2);
        drain();
    endtask
    task automatic t_format;
        @(negedge clk);
        ctrl.twos_comp = 1'b0;
        send(12'h900, 12'h900);
        burst(12'h700, 12'h700, 1);
        ctrl.twos_comp = 1'b1;
    endtask
    // Sink held off: input must refuse, then every word arrive in order
    task automatic t_fifo;
        hold = 1'b1;
        saw_low = 1'b0;
        fork
            for (int i = 0; i < 45; i++) send(12'h800 + 12'(i), 12'(i));
            begin
                repeat (100) @(negedge clk);
                hold = 1'b0;
            end
        join
        drain();
        chk_flag(saw_low, 1'b1);
    endtask
    // Gain factor is the ratio of 2.00 Vpp to each scaled full scale
    task automatic t_gain;
        real fs[13] = '{2.0, 1.89, 1.78, 1.68, 1.59, 1.5, 1.42, 1.34,
                        1.26, 1.19, 1.12, 1.06, 1.0};
        int g;
        slow = 1'b1;
        for (int c = 0; c < 13; c++) begin
            g = int'(2048.0 / fs[c]);
            // Loop stops at 12: codes 13 to 15 are reserved
            set_gain(4'(c));
            burst(12'ha00, 12'(g >> 1), 2);
        end
        // Negative full scale doubled must clip, not wrap
        burst(12'h000, 12'h800, 1);
        slow = 1'b0;
    endtask
    // First window is 1K, the next two 2K; DC words give known power
    task automatic t_level;
        ctrl.averaging_length_code = 3'h1;
        ctrl.level_meter_on = 1'b1;
        do_reset();
        burst(12'hfff, 12'h7ff, 1024);
        chk_lvl(lvl_seen, 4'he);
        burst(12'hc00, 12'h400, 1024);
        chk_lvl(lvl_seen, 4'he);
        burst(12'hc00, 12'h400, 1024);
        chk_lvl(lvl_seen, 4'hb);
        ctrl.level_meter_on = 1'b0;
        repeat (3) @(negedge clk);
        chk_lvl(lvl, 4'h0);
        ctrl.level_meter_on = 1'b1;
        repeat (3) @(negedge clk);
        chk_lvl(lvl, 4'hb);
        // Code above 4 is latched at this window end and clamps to 16K
        ctrl.averaging_length_code = 3'h7;
        burst(12'h800, 12'h000, 2048);
        chk_lvl(lvl_seen, 4'h1);
        burst(12'hfff, 12'h7ff, 16383);
        chk_lvl(lvl_seen, 4'h1);
        burst(12'hfff, 12'h7ff, 1);
        chk_lvl(lvl_seen, 4'he);
    endtask

    ////////////////////////////////////////
    initial begin
        ctrl.twos_comp = 1'b1;
        do_reset();
        t_latency();
        t_format();
        t_fifo();
        t_gain();
        t_level();
        give_verdict();
    end
endmodule
